// ===== rtl/lod_pkg.sv
// package for the lead-off detection control register block
package lod_pkg;

   // =====================================================================
   // register map
   // =====================================================================
   localparam logic [7:0]  LOD_CTRL_ADDR   = 8'h02;      // lead_off_control address
   localparam logic [23:0] LOD_CTRL_RESET  = 24'h000000; // reset value of whole register
   localparam logic [23:0] LOD_CTRL_WMASK  = 24'hfff19f; // writable bits, reserved cleared

   // =====================================================================
   // field positions
   // =====================================================================
   localparam int LOD_PH_HI    = 23; // excitation phase bits, top
   localparam int LOD_PH_LO    = 18; // excitation phase bits, bottom
   localparam int LOD_EN_HI    = 17; // per-electrode ac enables, top
   localparam int LOD_EN_LO    = 13; // per-electrode ac enables (not common electrode)
   localparam int LOD_CE_EN    = 12; // common electrode ac enable
   localparam int LOD_ACL_HI   = 8;  // ac excitation level, top
   localparam int LOD_ACL_LO   = 7;  // ac excitation level, bottom
   localparam int LOD_DCL_HI   = 4;  // dc excitation level, top
   localparam int LOD_DCL_LO   = 2;  // dc excitation level, bottom
   localparam int LOD_GLOBAL_AC_DETECT_SELECT    = 1;  // global ac detect select
   localparam int LOD_ENABLE   = 0;  // electrode detach enable

   // =====================================================================
   // excitation encodings
   // =====================================================================
   localparam logic [1:0] LOD_AC_12P5NA = 2'h0; // 12.5 nA rms
   localparam logic [1:0] LOD_AC_25NA   = 2'h1; // 25 nA rms
   localparam logic [1:0] LOD_AC_50NA   = 2'h2; // 50 nA rms
   localparam logic [1:0] LOD_AC_100NA  = 2'h3; // 100 nA rms
   localparam logic [2:0] LOD_DC_OFF    = 3'h0; // 0 nA, 10 nA per code up to 70 nA

endpackage

// ===== rtl/lod_sync2.sv
// two-flop synchroniser for an asynchronous level input
`timescale 1ns/100ps
module lod_sync2 (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic metaQ; // first stage, read only by second stage

   // =====================================================================
   // two stages
   // =====================================================================
   // reset to zero so the sampled level is defined after reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         metaQ   <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         metaQ   <= asyncIn;
         syncOut <= metaQ;
      end
   end
endmodule

// ===== rtl/lod_ctrl.sv
// lead-off detection control register and enable decode
`timescale 1ns/100ps

// Overview of operation
// - two-bit code selects ac excitation level
// - three-bit code selects dc level, dc only
// - global enable off means no detection
// - ac select ignored while detection off
// - dc mode still allows per-electrode ac
// - ac select: dc off, ac on limb and chest electrodes
// - limb and chest ac: select OR own
// - common electrode ac: own bit only
// - calibration dac on suppresses ac detection
// - per-electrode ac enables reset to zero
// - phase bits: zero in phase, one inverted
module lod_ctrl
   import lod_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [23:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [23:0] regRdata,
   input  wire logic        calDacEnable,
   output logic             dcDetectOn,
   output logic      [2:0]  dcExcitationLevel,
   output logic      [1:0]  acExcitationLevel,
   output logic      [5:0]  acDetectOn,
   output logic      [5:0]  excitationInvert
);

   // =====================================================================
   // register storage
   // =====================================================================
   logic [23:0] ctrl_q;        // lead_off_control contents
   logic [23:0] ctrl_d;        // next value
   logic [23:0] rdata_q;       // read data register
   logic        calDacSync;    // calibration dac level, synchronised

   // calibration dac enable comes from another block's pin, so resynchronise it
   lod_sync2 u_cal_sync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .asyncIn (calDacEnable),
      .syncOut (calDacSync)
   );

   // =====================================================================
   // decode
   // =====================================================================
   wire hitCtrl  = (regAddr == LOD_CTRL_ADDR);           // address decode
   wire wrCtrl   = regWr & hitCtrl;                      // write to this register
   // reserved positions are masked on write so they always read zero
   assign ctrl_d = wrCtrl ? (regWdata & LOD_CTRL_WMASK) : ctrl_q;

   // field views
   wire       detachEnable   = ctrl_q[LOD_ENABLE];                // electrode_detach_enable
   wire       globalAcSelect = ctrl_q[LOD_GLOBAL_AC_DETECT_SELECT];                 // global_ac_detect_select
   wire [2:0] dcLevel        = ctrl_q[LOD_DCL_HI:LOD_DCL_LO];     // dc_excitation_level
   wire [1:0] acLevel        = ctrl_q[LOD_ACL_HI:LOD_ACL_LO];     // ac_excitation_level
   wire [4:0] ownAcEnable    = ctrl_q[LOD_EN_HI:LOD_EN_LO];       // la, ll, ra, v1, v2
   wire       ceAcEnable     = ctrl_q[LOD_CE_EN];                 // common electrode
   wire [5:0] phaseBits      = ctrl_q[LOD_PH_HI:LOD_PH_LO];       // la..ce phase

   // ac select only means something while detection is on
   wire acSelEff  = detachEnable & globalAcSelect;
   // nothing is detected at all while the global enable is clear
   wire dcOnD     = detachEnable & ~globalAcSelect;
   // limb and chest electrodes: global select or the electrode's own bit
   wire [4:0] limbAcD = {5{detachEnable & ~calDacSync}} &
                        ({5{acSelEff}} | ownAcEnable);
   // common electrode is never enabled by the global select
   wire ceAcD     = detachEnable & ~calDacSync & ceAcEnable;
   // dc level only applies in dc mode, otherwise drive zero current
   wire [2:0] dcLevelD = dcOnD ? dcLevel : LOD_DC_OFF;

   // =====================================================================
   // register update and outputs
   // =====================================================================
   // outputs are registered so the analog side sees glitch-free controls
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrl_q            <= LOD_CTRL_RESET;
         rdata_q           <= 24'h000000;
         dcDetectOn        <= 1'b0;
         dcExcitationLevel <= LOD_DC_OFF;
         acExcitationLevel <= LOD_AC_12P5NA;
         acDetectOn        <= 6'h00;
         excitationInvert  <= 6'h00;
      end else begin
         ctrl_q            <= ctrl_d;
         rdata_q           <= (regRd & hitCtrl) ? ctrl_q : 24'h000000;
         dcDetectOn        <= dcOnD;
         dcExcitationLevel <= dcLevelD;
         acExcitationLevel <= acLevel;
         acDetectOn        <= {limbAcD, ceAcD};
         excitationInvert  <= phaseBits;
      end
   end

   assign regRdata = rdata_q;

   // =====================================================================
   // assertions
   // =====================================================================
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (srst)
      ((regRdata[11:9] == 3'h0) && (regRdata[6:5] == 2'h0)))
      else $error("reserved bits read nonzero");

   a_off_no_detect: assert property (@(posedge sys_clk) disable iff (srst)
      !$past(detachEnable) |-> (!dcDetectOn && (acDetectOn == 6'h00)))
      else $error("detection active while disabled");

   a_global_ac_detect_select_ignored: assert property (@(posedge sys_clk) disable iff (srst)
      (!detachEnable && globalAcSelect && !ceAcEnable && (ownAcEnable == 5'h00))
      |=> (acDetectOn == 6'h00))
      else $error("ac select acted while disabled");

   a_dc_mode: assert property (@(posedge sys_clk) disable iff (srst)
      (detachEnable && !globalAcSelect) |=> (dcDetectOn && dcExcitationLevel == $past(dcLevel)))
      else $error("dc mode not applied");

   a_ac_mode: assert property (@(posedge sys_clk) disable iff (srst)
      (detachEnable && globalAcSelect && !calDacSync)
      |=> (!dcDetectOn && acDetectOn[5:1] == 5'h1f && dcExcitationLevel == 3'h0))
      else $error("ac mode not applied");

   a_own_enable: assert property (@(posedge sys_clk) disable iff (srst)
      (detachEnable && !calDacSync) |=> (acDetectOn[5:1] == ($past(ownAcEnable) | {5{$past(globalAcSelect)}})))
      else $error("limb ac enable not or of bits");

   a_ce_own_only: assert property (@(posedge sys_clk) disable iff (srst)
      (detachEnable && !calDacSync) |=> (acDetectOn[0] == $past(ceAcEnable)))
      else $error("common electrode enable wrong");

   a_cal_suppress: assert property (@(posedge sys_clk) disable iff (srst)
      calDacSync |=> (acDetectOn == 6'h00))
      else $error("ac active with calibration dac");

   a_write_reads: assert property (@(posedge sys_clk) disable iff (srst)
      (wrCtrl && !regRd) ##1 (regRd && hitCtrl && !regWr)
      |=> (regRdata == ($past(regWdata, 2) & LOD_CTRL_WMASK)))
      else $error("readback mismatch");

   a_phase_follow: assert property (@(posedge sys_clk) disable iff (srst)
      (wrCtrl ##1 !wrCtrl) |=> (excitationInvert == $past(regWdata[LOD_PH_HI:LOD_PH_LO], 2)))
      else $error("phase bits not applied");

   a_ac_level: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 (acExcitationLevel == $past(acLevel)))
      else $error("ac level not applied");

endmodule

// ===== verification/lod_host_model.sv
// host model: software side that writes and reads the control register
`timescale 1ns/100ps
module lod_host_model (
   input  wire logic        sys_clk,
   output logic      [7:0]  regAddr,
   output logic      [23:0] regWdata,
   output logic             regWr,
   output logic             regRd,
   input  wire logic [23:0] regRdata
);
   // =====================================================
   // bus cycles, one strobe cycle each, changed after edges
   // =====================================================
   initial begin
      regAddr = 8'h00;
      regWdata = 24'h000000;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   // one write cycle; callers keep reserved bits zero unless probing them
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   // read data only stand in the cycle after the strobe, so sample just then
   task automatic rd(input logic [7:0] a, output logic [23:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
endmodule

// ===== verification/lead_off_detect_control_bench.sv
// self-checking bench for the lead-off detection control register block
`timescale 1ns/100ps
module lead_off_detect_control_bench;
   import lod_pkg::*;
   // =====================================================
   // wiring
   // =====================================================
   logic        sys_clk, srst, calDacEnable, regWr, regRd, dcDetectOn;
   logic [7:0]  regAddr;
   logic [23:0] regWdata, regRdata, rdVal;
   logic [2:0]  dcExcitationLevel;
   logic [1:0]  acExcitationLevel;
   logic [5:0]  acDetectOn, excitationInvert;
   wire  [17:0] outs = {dcDetectOn, dcExcitationLevel, acExcitationLevel, acDetectOn, excitationInvert};
   int          miscompares = 0;
   int          totalChecks = 0;
   lod_host_model u_host (.sys_clk(sys_clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata));
   lod_ctrl u_dut (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .calDacEnable(calDacEnable), .dcDetectOn(dcDetectOn),
      .dcExcitationLevel(dcExcitationLevel), .acExcitationLevel(acExcitationLevel),
      .acDetectOn(acDetectOn), .excitationInvert(excitationInvert));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // =====================================================
   // helpers
   // =====================================================
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // derived outputs trail the write by one cycle; three gives margin
   task automatic setReg(input logic [23:0] d);
      u_host.wr(LOD_CTRL_ADDR, d);
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   task automatic end_sim();
      $display("checks=%0d miscompares=%0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // =====================================================
   // scenarios
   // =====================================================
   task automatic t_reserved();
      u_host.rd(LOD_CTRL_ADDR, rdVal);
      chk(rdVal, 24'h000000);
      chk({6'h0, outs}, 24'h000000);
      setReg(24'hffffff);
      u_host.rd(LOD_CTRL_ADDR, rdVal);
      chk(rdVal, 24'hfff19f);
      chk({6'h0, outs}, {6'h0, 1'b0, 3'h0, 2'h3, 6'h3f, 6'h3f});
      u_host.rd(8'h03, rdVal);
      chk(rdVal, 24'h000000);
      $display("reserved and reset test done");
   endtask
   // every dc and ac code in dc mode, common electrode on by its own bit
   task automatic t_dcmode();
      for (int i = 0; i < 8; i++) begin
         setReg({11'h0, 1'b1, 3'h0, i[1:0], 2'h0, i[2:0], 1'b0, 1'b1});
         chk({6'h0, outs}, {6'h0, 1'b1, i[2:0], i[1:0], 6'h01, 6'h00});
      end
      $display("dc mode test done");
   endtask
   task automatic t_global_ac_detect_select();
      setReg(24'ha8001f);
      chk({6'h0, outs}, {6'h0, 1'b0, 3'h0, 2'h0, 6'h3e, 6'h2a});
      setReg(24'ha8001e);
      chk({6'h0, outs}, {6'h0, 1'b0, 3'h0, 2'h0, 6'h00, 6'h2a});
      $display("ac select test done");
   endtask
   // calibration input crosses a two-flop synchroniser, so allow four cycles
   task automatic t_caldac();
      setReg(24'h03f001);
      chk({6'h0, outs}, {6'h0, 1'b1, 3'h0, 2'h0, 6'h3f, 6'h00});
      @(posedge sys_clk);
      calDacEnable <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 chk({6'h0, outs}, {6'h0, 1'b1, 3'h0, 2'h0, 6'h00, 6'h00});
      @(posedge sys_clk);
      calDacEnable <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 chk({6'h0, outs}, {6'h0, 1'b1, 3'h0, 2'h0, 6'h3f, 6'h00});
      $display("calibration test done");
   endtask
   initial begin
      repeat (2000) @(posedge sys_clk);
      miscompares++;
      end_sim();
   end
   initial begin
      srst = 1'b1;
      calDacEnable = 1'b0;
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      t_reserved();
      t_dcmode();
      t_global_ac_detect_select();
      t_caldac();
      end_sim();
   end
endmodule
